/* File: src/tag_cmd_pkg.sv */
// Package with command codes, frame layout and state encoding for the tag command machine.
package tag_cmd_pkg;
    // Command byte codes.
    localparam logic [7:0] CMD_ENUM_PREFIX  = 8'h06;
    localparam logic [7:0] CMD_BEGIN_INV_2  = 8'h00;
    localparam logic [7:0] CMD_SLOT_POLL_2  = 8'h04;
    localparam logic [3:0] CMD_PROBE_LOW    = 4'h6;
    localparam logic [7:0] CMD_BLOCK_FETCH  = 8'h08;
    localparam logic [7:0] CMD_BLOCK_STORE  = 8'h09;
    localparam logic [7:0] CMD_SERIAL_FETCH = 8'h0b;
    localparam logic [7:0] CMD_BACK_CENSUS  = 8'h0c;
    localparam logic [7:0] CMD_CHOOSE_TAG   = 8'h0e;
    localparam logic [7:0] CMD_RETIRE       = 8'h0f;
    // Frame shape: check bytes that trail every frame.
    localparam int CHECK_BYTES = 2;
    // Random generator seed and feedback taps, values after reset.
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [7:0]  IDENT_RESET = 8'h00;
    // Bytes buffered for one request: up to two bytes before the check bytes.
    localparam int REQ_MAX = 2;
    // Tag life cycle states.
    typedef enum logic [2:0] {
        ST_READY,
        ST_INVENTORY,
        ST_SELECTED,
        ST_DESELECTED,
        ST_DEACTIVATED
    } tag_state_t;
    // Reply sequencer states.
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_IDENT,
        TX_CHK_LO,
        TX_CHK_HI
    } tx_state_t;
endpackage

/* File: src/frame_if.sv */
// Interface carrying one decoded request frame from the collector to the tag machine.
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
    logic       valid;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [1:0] count;
    logic       check_ok;
    modport src (output valid, output byte0, output byte1, output count, output check_ok);
    modport dst (input valid, input byte0, input byte1, input count, input check_ok);
endinterface
`default_nettype wire

/* File: src/frame_collect.sv */
// Collector that gathers request bytes up to the end of frame and hands them on.
`timescale 1ns/10ps
`default_nettype none
module frame_collect (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Received byte stream.
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_eof,
    input  wire logic       rx_crc_ok,
    // Collected frame.
    frame_if.src            frm
);
    typedef struct packed {
        logic       valid;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [2:0] n;
        logic [1:0] cnt;
        logic       ok;
    } col_t;
    col_t s_r;
    col_t s_nxt;

    // Count bytes; check bytes are included, so the payload is total minus two.
    always_comb begin
        s_nxt = s_r;
        s_nxt.valid = 1'b0;
        if (rx_valid && s_r.n < 3'd7) begin
            if (s_r.n == 3'd0) begin
                s_nxt.b0 = rx_data;
            end
            if (s_r.n == 3'd1) begin
                s_nxt.b1 = rx_data;
            end
            s_nxt.n = s_r.n + 3'd1;
        end
        if (rx_eof) begin
            // Frames longer than the buffer are marked bad, the tag never acts on them.
            s_nxt.valid = 1'b1;
            s_nxt.ok = rx_crc_ok && s_r.n >= 3'(tag_cmd_pkg::CHECK_BYTES + 1)
                       && s_r.n <= 3'(tag_cmd_pkg::CHECK_BYTES + tag_cmd_pkg::REQ_MAX);
            s_nxt.cnt = 2'(s_r.n - 3'(tag_cmd_pkg::CHECK_BYTES));
            s_nxt.n = 3'd0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign frm.valid    = s_r.valid;
    assign frm.byte0    = s_r.b0;
    assign frm.byte1    = s_r.b1;
    assign frm.count    = s_r.cnt;
    assign frm.check_ok = s_r.ok;

    a_eof_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_eof |=> frm.valid) else $error("frame not handed on after end of frame");
    a_bad_crc: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_eof && !rx_crc_ok |=> !frm.check_ok) else $error("bad check accepted");
endmodule
`default_nettype wire

/* File: src/reply_send.sv */
// Reply sequencer: sends identifier byte then the two check byte slots.
`timescale 1ns/10ps
`default_nettype none
module reply_send (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Request to send.
    input  wire logic       start,
    input  wire logic [7:0] ident,
    // Byte stream out.
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_check_lo,
    output logic            tx_check_hi,
    output logic            busy
);
    typedef struct packed {
        tag_cmd_pkg::tx_state_t st;
        logic [7:0]             id;
        logic                   v;
        logic [7:0]             d;
        logic                   lo;
        logic                   hi;
    } snd_t;
    snd_t s_r;
    snd_t s_nxt;

    // Advance one byte per accepted transfer; the check bytes are filled by the coder.
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            tag_cmd_pkg::TX_IDLE: begin
                if (start) begin
                    s_nxt.st = tag_cmd_pkg::TX_IDENT;
                    s_nxt.id = ident;
                end
            end
            tag_cmd_pkg::TX_IDENT: begin
                if (tx_ready) begin
                    s_nxt.st = tag_cmd_pkg::TX_CHK_LO;
                end
            end
            tag_cmd_pkg::TX_CHK_LO: begin
                if (tx_ready) begin
                    s_nxt.st = tag_cmd_pkg::TX_CHK_HI;
                end
            end
            tag_cmd_pkg::TX_CHK_HI: begin
                if (tx_ready) begin
                    s_nxt.st = tag_cmd_pkg::TX_IDLE;
                end
            end
            default: s_nxt.st = tag_cmd_pkg::TX_IDLE;
        endcase
        // Outputs are registered from the next state, so the pins come from flops with no extra delay.
        s_nxt.v  = s_nxt.st != tag_cmd_pkg::TX_IDLE;
        s_nxt.d  = (s_nxt.st == tag_cmd_pkg::TX_IDENT) ? s_nxt.id : 8'h00;
        s_nxt.lo = s_nxt.st == tag_cmd_pkg::TX_CHK_LO;
        s_nxt.hi = s_nxt.st == tag_cmd_pkg::TX_CHK_HI;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '{st: tag_cmd_pkg::TX_IDLE, id: tag_cmd_pkg::IDENT_RESET, v: 1'b0, d: 8'h00,
                     lo: 1'b0, hi: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_valid    = s_r.v;
    assign tx_data     = s_r.d;
    assign tx_check_lo = s_r.lo;
    assign tx_check_hi = s_r.hi;
    assign busy        = s_r.v;

    a_reply_order: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_valid && tx_ready && s_r.st == tag_cmd_pkg::TX_IDENT |=> tx_check_lo)
        else $error("check low byte does not follow identifier");
endmodule
`default_nettype wire

/* File: src/tag_anticollision_command_fsm.sv */
// Tag command decoder and life cycle state machine for enumeration, selection and retirement.
// Notes on behaviour
// - Begin-inventory is bytes 06h then 00h, then the two check bytes.
// - Begin-inventory in Ready: go to Inventory, draw new 8-bit identifier, reply.
// - Begin-inventory reply ignores the slot draw.
// - Slot poll (06h 04h) and slot probe only act in Inventory.
// - Slot poll first draws a new 0..15 slot into identifier low nibble.
// - Slot value holds until next poll, begin-inventory or power loss.
// - After poll draw, reply only when slot is zero.
// - Slot probe byte: low nibble 6, high nibble index 1..15.
// - Slot probe replies only when stored slot equals index.
// - Before selection, only the three enumeration commands and select 0Eh are accepted.
// - Select 0Eh with matching identifier enters Selected and echoes identifier.
// - Selected tag seeing select with another identifier becomes Deselected.
// - Retire 0Fh while Selected: Deactivated, silent, deaf until power loss.
// - Retire outside Selected is ignored silently.
// - Reply is identifier byte, then check low byte, then check high byte.
// - Back-to-census 0Ch returns Selected to Inventory silently; others ignore.
// - Memory fetch, store and serial fetch ignored unless Selected.
`timescale 1ns/10ps
`default_nettype none
module tag_anticollision_command_fsm (
    // Clock and power-on reset.
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Request byte stream from the frame decoder.
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_eof,
    input  wire logic       rx_crc_ok,
    // Reply byte stream to the frame coder.
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_check_lo,
    output logic            tx_check_hi,
    // Memory command hand-off, legal only in Selected.
    output logic            mem_cmd_valid,
    output logic [7:0]      mem_cmd_code,
    // Visible state.
    output logic [2:0]      tag_state,
    output logic [7:0]      tag_ident,
    output logic            ident_valid
);
    frame_if frm ();

    frame_collect u_collect (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .rx_valid  (rx_valid),
        .rx_data   (rx_data),
        .rx_eof    (rx_eof),
        .rx_crc_ok (rx_crc_ok),
        .frm       (frm)
    );

    typedef struct packed {
        tag_cmd_pkg::tag_state_t st;
        logic [7:0]              ident;
        logic                    id_ok;
        logic [15:0]             lfsr;
        logic                    reply;
        logic                    mem_v;
        logic [7:0]              mem_c;
    } tag_t;
    tag_t s_r;
    tag_t s_nxt;

    logic tx_busy;
    logic [7:0] c0;
    logic [7:0] c1;
    logic good;
    logic is_begin;
    logic is_poll;
    logic is_probe;
    logic is_mem;
    logic lfsr_fb;

    // Decode the received frame; a failed check or a reply still in progress drops it.
    always_comb begin
        c0 = frm.byte0;
        c1 = frm.byte1;
        good = frm.valid && frm.check_ok && !tx_busy;
        is_begin = good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_ENUM_PREFIX
                   && c1 == tag_cmd_pkg::CMD_BEGIN_INV_2;
        is_poll = good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_ENUM_PREFIX
                  && c1 == tag_cmd_pkg::CMD_SLOT_POLL_2;
        is_probe = good && frm.count == 2'd1 && c0[3:0] == tag_cmd_pkg::CMD_PROBE_LOW
                   && c0[7:4] != 4'h0;
        is_mem = good && (c0 == tag_cmd_pkg::CMD_BLOCK_FETCH || c0 == tag_cmd_pkg::CMD_BLOCK_STORE
                 || c0 == tag_cmd_pkg::CMD_SERIAL_FETCH);
        lfsr_fb = ^(s_r.lfsr & tag_cmd_pkg::LFSR_TAPS);
    end

    // Main state machine: the random source runs every cycle so draws depend on timing.
    always_comb begin
        s_nxt = s_r;
        s_nxt.lfsr = {s_r.lfsr[14:0], lfsr_fb};
        s_nxt.reply = 1'b0;
        s_nxt.mem_v = 1'b0;
        case (s_r.st)
            tag_cmd_pkg::ST_READY: begin
                if (is_begin) begin
                    s_nxt.st = tag_cmd_pkg::ST_INVENTORY;
                    s_nxt.ident = s_r.lfsr[7:0];
                    s_nxt.id_ok = 1'b1;
                    s_nxt.reply = 1'b1;
                end
            end
            tag_cmd_pkg::ST_INVENTORY: begin
                if (is_begin) begin
                    // Begin-inventory outside Ready only redraws nothing; it is ignored.
                    s_nxt.st = tag_cmd_pkg::ST_INVENTORY;
                end else if (is_poll) begin
                    s_nxt.ident[3:0] = s_r.lfsr[3:0];
                    s_nxt.reply = s_r.lfsr[3:0] == 4'h0;
                end else if (is_probe) begin
                    s_nxt.reply = s_r.ident[3:0] == c0[7:4];
                end else if (good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_CHOOSE_TAG
                             && c1 == s_r.ident) begin
                    s_nxt.st = tag_cmd_pkg::ST_SELECTED;
                    s_nxt.reply = 1'b1;
                end
                // Anything else is refused before selection.
            end
            tag_cmd_pkg::ST_SELECTED: begin
                if (good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_CHOOSE_TAG) begin
                    if (c1 == s_r.ident) begin
                        s_nxt.reply = 1'b1;
                    end else begin
                        s_nxt.st = tag_cmd_pkg::ST_DESELECTED;
                    end
                end else if (good && frm.count == 2'd1 && c0 == tag_cmd_pkg::CMD_RETIRE) begin
                    s_nxt.st = tag_cmd_pkg::ST_DEACTIVATED;
                end else if (good && frm.count == 2'd1 && c0 == tag_cmd_pkg::CMD_BACK_CENSUS) begin
                    s_nxt.st = tag_cmd_pkg::ST_INVENTORY;
                end else if (is_mem) begin
                    s_nxt.mem_v = 1'b1;
                    s_nxt.mem_c = c0;
                end
            end
            tag_cmd_pkg::ST_DESELECTED: begin
                // A repeated select naming this tag brings it back.
                if (good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_CHOOSE_TAG
                    && c1 == s_r.ident) begin
                    s_nxt.st = tag_cmd_pkg::ST_SELECTED;
                    s_nxt.reply = 1'b1;
                end
            end
            tag_cmd_pkg::ST_DEACTIVATED: begin
                s_nxt.st = tag_cmd_pkg::ST_DEACTIVATED;
            end
            default: s_nxt.st = tag_cmd_pkg::ST_READY;
        endcase
    end

    // Power-on reset clears identifier and slot; the seed must be nonzero for the shifter.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '{st: tag_cmd_pkg::ST_READY, ident: tag_cmd_pkg::IDENT_RESET, id_ok: 1'b0,
                     lfsr: tag_cmd_pkg::LFSR_SEED, reply: 1'b0, mem_v: 1'b0, mem_c: 8'h00};
        end else begin
            s_r <= s_nxt;
        end
    end

    reply_send u_reply (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .start       (s_r.reply),
        .ident       (s_r.ident),
        .tx_ready    (tx_ready),
        .tx_valid    (tx_valid),
        .tx_data     (tx_data),
        .tx_check_lo (tx_check_lo),
        .tx_check_hi (tx_check_hi),
        .busy        (tx_busy)
    );

    // Outputs straight from registers.
    assign mem_cmd_valid = s_r.mem_v;
    assign mem_cmd_code  = s_r.mem_c;
    assign tag_state     = s_r.st;
    assign tag_ident     = s_r.ident;
    assign ident_valid   = s_r.id_ok;

    a_begin_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_begin && s_r.st == tag_cmd_pkg::ST_READY |=> s_r.st == tag_cmd_pkg::ST_INVENTORY && s_r.reply)
        else $error("begin-inventory did not enter Inventory with reply");
    a_poll_slot_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_poll && s_r.st == tag_cmd_pkg::ST_INVENTORY |=> s_r.reply == (s_r.ident[3:0] == 4'h0))
        else $error("poll reply not tied to slot zero");
    a_slot_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !is_poll && !is_begin |=> $stable(s_r.ident[3:0]))
        else $error("slot value changed without a draw");
    a_probe_match: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_probe && s_r.st == tag_cmd_pkg::ST_INVENTORY |=> s_r.reply == (s_r.ident[3:0] == $past(c0[7:4])))
        else $error("probe reply wrong");
    a_enum_only_inv: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_poll || is_probe) && s_r.st != tag_cmd_pkg::ST_INVENTORY |=> !s_r.reply)
        else $error("enumeration answered outside Inventory");
    a_deselect: assert property (@(posedge core_clk) disable iff (sys_rst)
        good && frm.count == 2'd2 && c0 == tag_cmd_pkg::CMD_CHOOSE_TAG && c1 != s_r.ident
        && s_r.st == tag_cmd_pkg::ST_SELECTED |=> s_r.st == tag_cmd_pkg::ST_DESELECTED)
        else $error("select with other identifier did not deselect");
    a_retire_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_r.st == tag_cmd_pkg::ST_DEACTIVATED |=> s_r.st == tag_cmd_pkg::ST_DEACTIVATED && !s_r.reply)
        else $error("retired tag left Deactivated");
    a_retire_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
        good && frm.count == 2'd1 && c0 == tag_cmd_pkg::CMD_RETIRE && s_r.st != tag_cmd_pkg::ST_SELECTED
        |=> $stable(s_r.st) && !s_r.reply)
        else $error("retire acted on outside Selected");
    a_bad_frame: assert property (@(posedge core_clk) disable iff (sys_rst)
        frm.valid && !frm.check_ok |=> $stable(s_r.st) && !s_r.reply)
        else $error("bad frame changed state");
    a_mem_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_r.mem_v |-> $past(s_r.st) == tag_cmd_pkg::ST_SELECTED)
        else $error("memory command passed outside Selected");
    a_census_back: assert property (@(posedge core_clk) disable iff (sys_rst)
        good && frm.count == 2'd1 && c0 == tag_cmd_pkg::CMD_BACK_CENSUS && s_r.st == tag_cmd_pkg::ST_SELECTED
        |=> s_r.st == tag_cmd_pkg::ST_INVENTORY && !s_r.reply)
        else $error("back-to-census failed");
endmodule
`default_nettype wire

/* File: bench/reader_model.sv */
// Reader model that sends request frames to the tag and collects its reply slots.
`timescale 1ns/10ps
`default_nettype none
module reader_model (
    // Clock.
    input  wire logic       core_clk,
    // Request byte stream to the tag.
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_eof,
    output logic            rx_crc_ok,
    // Reply byte stream from the tag.
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_check_lo,
    input  wire logic       tx_check_hi,
    // Memory hand-off, watched for pulses.
    input  wire logic       mem_cmd_valid,
    input  wire logic [7:0] mem_cmd_code
);
    int         n_slots = 0;
    int         mem_hits = 0;
    logic [7:0] mem_last = 8'h00;
    logic [7:0] slot_data [3];
    logic [1:0] slot_mark [3];

    // Idle link at time zero.
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_eof = 1'b0;
        rx_crc_ok = 1'b0;
        tx_ready = 1'b0;
    end

    // Count hand-off pulses; a pulse stands one cycle, so it is sampled on every edge.
    always @(posedge core_clk) begin
        if (mem_cmd_valid === 1'b1) begin
            mem_hits <= mem_hits + 1;
            mem_last <= mem_cmd_code;
        end
    end

    // One byte for one cycle; the strobe stays up between bytes and the frame task drops it.
    task automatic put_byte(input logic [7:0] b);
        rx_valid = 1'b1;
        rx_data = b;
        @(posedge core_clk);
        #1;
    endtask

    // Whole frame: payload, two check bytes, end marker with verdict, then up to three reply slots.
    task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input int nbytes,
                              input logic crc_good, input int stall);
        int k;
        put_byte(b0);
        if (nbytes > 1) begin
            put_byte(b1);
        end
        put_byte(b0 ^ 8'h5a);
        put_byte(b1 ^ 8'ha5);
        // The idle line shows the inverse of the last byte, so stale data is never mistaken.
        rx_valid = 1'b0;
        rx_data = ~(b1 ^ 8'ha5);
        rx_eof = 1'b1;
        rx_crc_ok = crc_good;
        @(posedge core_clk);
        #1;
        rx_eof = 1'b0;
        rx_crc_ok = 1'b0;
        n_slots = 0;
        for (int j = 0; j < 3; j++) begin
            k = 0;
            while (tx_valid !== 1'b1 && k < 10) begin
                @(posedge core_clk);
                #1;
                k++;
            end
            if (tx_valid !== 1'b1) begin
                break;
            end
            slot_data[j] = tx_data;
            slot_mark[j] = {tx_check_hi, tx_check_lo};
            // A slow reader drops ready and leaves the slot waiting; the tag must hold it.
            if (stall > 0) begin
                tx_ready = 1'b0;
                repeat (stall) begin
                    @(posedge core_clk);
                    #1;
                end
            end
            tx_ready = 1'b1;
            @(posedge core_clk);
            #1;
            n_slots++;
        end
        tx_ready = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: bench/tag_anticollision_command_fsm_tb.sv */
// Self-checking testbench for the tag command machine, driven through the reader model.
`timescale 1ns/10ps
`default_nettype none
module tag_anticollision_command_fsm_tb;
    logic        core_clk;
    logic        sys_rst;
    logic        rx_valid, rx_eof, rx_crc_ok, tx_ready, tx_valid, tx_check_lo, tx_check_hi;
    logic        mem_cmd_valid, ident_valid;
    logic [7:0]  rx_data, tx_data, mem_cmd_code, tag_ident, id, other;
    logic [2:0]  tag_state;
    logic [15:0] rnd;
    int          err_count;
    int          check_count;
    int          hits;
    logic [7:0]  mem_codes [3] = '{8'h08, 8'h09, 8'h0b};

    reader_model rdr (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
        .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_check_lo(tx_check_lo), .tx_check_hi(tx_check_hi), .mem_cmd_valid(mem_cmd_valid),
        .mem_cmd_code(mem_cmd_code));

    tag_anticollision_command_fsm uut (.core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_check_lo(tx_check_lo), .tx_check_hi(tx_check_hi),
        .mem_cmd_valid(mem_cmd_valid), .mem_cmd_code(mem_cmd_code), .tag_state(tag_state),
        .tag_ident(tag_ident), .ident_valid(ident_valid));

    // Repeatable pseudo-random source for stalls and wrong identifiers.
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Compare and count.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Send a frame with a random reply stall.
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n, input logic good);
        rnd = lfsr_next(rnd);
        rdr.send_frame(b0, b1, n, good, int'(rnd[1:0]));
    endtask

    // A reply is the identifier, then the low and the high check slot; silence is no slot at all.
    task automatic got(input logic want);
        check("reply slots", 8'(rdr.n_slots), want ? 8'h03 : 8'h00);
        if (want) begin
            check("reply ident", rdr.slot_data[0], tag_ident);
            check("slot marks", {rdr.slot_mark[0], rdr.slot_mark[1], rdr.slot_mark[2], 2'b00}, 8'h18);
        end
    endtask

    task automatic state_is(input tag_cmd_pkg::tag_state_t s);
        check("state", 8'(tag_state), 8'(s));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Whole run is a few thousand cycles; this margin only trips on a hang.
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_sim();
    end

    initial begin
        sys_rst = 1'b1;
        rnd = 16'h0020;
        err_count = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        state_is(tag_cmd_pkg::ST_READY);
        check("ident valid", 8'(ident_valid), 8'h00);
        // Everything but begin-inventory is refused in Ready.
        frame(8'h0f, 8'h00, 1, 1'b1);
        got(1'b0);
        frame(8'h06, 8'h04, 2, 1'b1);
        got(1'b0);
        frame(8'h36, 8'h00, 1, 1'b1);
        got(1'b0);
        frame(8'h0e, 8'h00, 2, 1'b1);
        got(1'b0);
        frame(8'h0c, 8'h00, 1, 1'b1);
        got(1'b0);
        frame(8'h08, 8'h01, 2, 1'b1);
        check("mem pulses", 8'(rdr.mem_hits), 8'h00);
        frame(8'h06, 8'h00, 2, 1'b0);
        got(1'b0);
        state_is(tag_cmd_pkg::ST_READY);
        frame(8'h06, 8'h00, 2, 1'b1);
        got(1'b1);
        state_is(tag_cmd_pkg::ST_INVENTORY);
        check("ident valid", 8'(ident_valid), 8'h01);
        // Enumeration: each poll redraws the slot, then every probe index is tried.
        for (int p = 0; p < 6; p++) begin
            id = tag_ident;
            frame(8'h06, 8'h04, 2, 1'b1);
            check("ident high", {4'h0, tag_ident[7:4]}, {4'h0, id[7:4]});
            got(tag_ident[3:0] == 4'h0);
            id = tag_ident;
            for (int s = 1; s < 16; s++) begin
                frame({4'(s), tag_cmd_pkg::CMD_PROBE_LOW}, 8'h00, 1, 1'b1);
                got(id[3:0] == 4'(s));
            end
            check("slot kept", tag_ident, id);
        end
        // A wrong identifier can never equal ours: the xor mask is odd.
        rnd = lfsr_next(rnd);
        other = id ^ (rnd[7:0] | 8'h01);
        frame(8'h0e, other, 2, 1'b1);
        got(1'b0);
        frame(8'h0e, id, 2, 1'b1);
        got(1'b1);
        check("select echo", rdr.slot_data[0], id);
        state_is(tag_cmd_pkg::ST_SELECTED);
        for (int m = 0; m < 3; m++) begin
            frame(mem_codes[m], rnd[15:8], 2, 1'b1);
            check("mem pulses", 8'(rdr.mem_hits), 8'(m + 1));
            check("mem code", rdr.mem_last, mem_codes[m]);
        end
        frame(8'h0c, 8'h00, 1, 1'b1);
        got(1'b0);
        state_is(tag_cmd_pkg::ST_INVENTORY);
        frame(8'h0e, id, 2, 1'b1);
        got(1'b1);
        frame(8'h0e, other, 2, 1'b1);
        got(1'b0);
        state_is(tag_cmd_pkg::ST_DESELECTED);
        frame(8'h0f, 8'h00, 1, 1'b1);
        state_is(tag_cmd_pkg::ST_DESELECTED);
        frame(8'h0e, id, 2, 1'b1);
        got(1'b1);
        frame(8'h0f, 8'h00, 1, 1'b0);
        state_is(tag_cmd_pkg::ST_SELECTED);
        frame(8'h0f, 8'h00, 1, 1'b1);
        got(1'b0);
        state_is(tag_cmd_pkg::ST_DEACTIVATED);
        hits = rdr.mem_hits;
        frame(8'h0e, id, 2, 1'b1);
        got(1'b0);
        frame(8'h06, 8'h00, 2, 1'b1);
        got(1'b0);
        frame(8'h09, 8'h07, 2, 1'b1);
        check("mem pulses", 8'(rdr.mem_hits), 8'(hits));
        state_is(tag_cmd_pkg::ST_DEACTIVATED);
        // Power loss in mid-run brings the tag back to Ready.
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        state_is(tag_cmd_pkg::ST_READY);
        check("ident", tag_ident, tag_cmd_pkg::IDENT_RESET);
        check("ident valid", 8'(ident_valid), 8'h00);
        frame(8'h06, 8'h00, 2, 1'b1);
        got(1'b1);
        state_is(tag_cmd_pkg::ST_INVENTORY);
        end_sim();
    end
endmodule
`default_nettype wire
